// file: inc/ppm_defines.svh
// Register offsets, field positions, reset values and pin layout macros.
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PPM_OUT0_OFS    8'h00
`define PPM_OUT1_OFS    8'h04
`define PPM_OUT2_OFS    8'h08
`define PPM_OUT4_OFS    8'h0C
`define PPM_DIR0_OFS    8'h10
`define PPM_DIR1_OFS    8'h14
`define PPM_DIR2_OFS    8'h18
`define PPM_DIR4_OFS    8'h1C
`define PPM_PULLUP_OFS  8'h20
`define PPM_DRVA_OFS    8'h24
`define PPM_DRVB_OFS    8'h28
`define PPM_FUNC_OFS    8'h2C
`define PPM_PINS_OFS    8'h30
`define PPM_ISTAT_OFS   8'h34
`define PPM_ICLR_OFS    8'h38
`define PPM_IEN_OFS     8'h3C

// ----------------------------------------------------------------------------
// Pin vector layout
// ----------------------------------------------------------------------------
`define PPM_NPINS       31
`define PPM_P0_LSB      0
`define PPM_P1_LSB      8
`define PPM_P2_LSB      16
`define PPM_P4_LSB      23
`define PPM_SCK_BIT     16
`define PPM_SO_BIT      17
`define PPM_SI_BIT      18
`define PPM_P25_BIT     21
`define PPM_P26_BIT     22

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPM_DRVA_P0_BIT 0
`define PPM_DRVA_P1_BIT 1
`define PPM_DRVB_P25    5
`define PPM_DRVB_P26    6
`define PPM_FN_SER_BIT  0
`define PPM_FN_TO_BIT   1
`define PPM_FN_TI_BIT   2
`define PPM_FN_KR_BIT   3
`define PPM_FN_EDGE_LSB 4
`define PPM_IRQ_EXT_BIT 0
`define PPM_IRQ_KR_BIT  1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PPM_DIR_RST     8'hFF
`define PPM_ZERO_RST    32'h0000_0000

`endif

// file: inc/ppm_pkg.sv
// Types shared by the port pin and alternate function multiplexer.
package ppm_pkg;

  // --------------------------------------------------------------------------
  // Bus request carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ppm_wb_req_t;

  // --------------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PPM_EDGE_NONE = 2'h0,
    PPM_EDGE_RISE = 2'h1,
    PPM_EDGE_FALL = 2'h2,
    PPM_EDGE_BOTH = 2'h3
  } ppm_edge_t;

  typedef enum logic [1:0] {
    PPM_BUS_IDLE = 2'h1,
    PPM_BUS_ACK  = 2'h2
  } ppm_bus_st_t;

endpackage

// file: rtl/ppm_edge_det.sv
// Registered edge detector for a group of synchronous input levels.
`timescale 1ns/10ps

module ppm_edge_det #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         en_i,
  input  wire logic         rise_en_i,
  input  wire logic         fall_en_i,
  // Levels and events
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] evt_o
);

  logic [W-1:0] prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= '0;
    else
      prev_q <= lvl_i;
  end

  // Event is suppressed while disabled so a stale edge is not reported.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_o <= '0;
    else
      evt_o <= {W{en_i}} & (({W{rise_en_i}} & lvl_i & ~prev_q) |
                            ({W{fall_en_i}} & ~lvl_i & prev_q));
  end

endmodule // ppm_edge_det

// file: rtl/ppm_top.sv
// Port pins, drive modes and alternate function multiplexing for four ports.
`timescale 1ns/10ps
`include "ppm_defines.svh"

// ----------------------------------------------------------------------------
// Summary of operation
// [RL1] Port0, port1 and port4 are 8-bit ports with per-pin direction.
// [RL2] Port2 has seven pins with per-pin direction and no eighth pin.
// [RL3] An input pin gets its pull-up only when its pull-up option bit is set.
// [RL4] Port0 and port1 each choose push-pull or open-drain for all pins.
// [RL5] Port2 pins 5 and 6 each choose push-pull or open-drain on their own.
// [RL6] After reset every pin is an input, alternate outputs included.
// [RL7] Port2 pins 0, 1 and 2 carry serial clock, serial out and serial in.
// [RL8] Port2 pin 6 carries the interrupt input, timer clock and timer output.
// [RL9] The external interrupt fires on a rising, falling or either edge.
// [RL10] Each port4 pin can serve as a key-return detection input.
// [RL11] Each port has a direction register with one bit per pin.
// [RL12] Software sets direction and latch to suit the serial function used.
// [RL13] A pin set as output never has its pull-up connected.
// ----------------------------------------------------------------------------

module ppm_top (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire ppm_pkg::ppm_wb_req_t wb_req_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // Port0 pins
  input  wire logic [7:0]         port0_pins_i,
  output logic [7:0]              port0_pins_o,
  output logic [7:0]              port0_pins_oe_o,
  output logic [7:0]              port0_pullup_o,
  // Port1 pins
  input  wire logic [7:0]         port1_pins_i,
  output logic [7:0]              port1_pins_o,
  output logic [7:0]              port1_pins_oe_o,
  output logic [7:0]              port1_pullup_o,
  // Port2 pins
  input  wire logic [6:0]         port2_pins_i,
  output logic [6:0]              port2_pins_o,
  output logic [6:0]              port2_pins_oe_o,
  output logic [6:0]              port2_pullup_o,
  // Port4 pins
  input  wire logic [7:0]         port4_pins_i,
  output logic [7:0]              port4_pins_o,
  output logic [7:0]              port4_pins_oe_o,
  output logic [7:0]              port4_pullup_o,
  // Serial interface side
  input  wire logic               serial_clock_drv_i,
  input  wire logic               serial_clock_oe_i,
  input  wire logic               serial_out_drv_i,
  output logic                    serial_clock_pin_o,
  output logic                    serial_in_pin_o,
  // Timer side
  input  wire logic               timer_output_pin_i,
  output logic                    timer_count_clock_in_o,
  // Interrupt and key-return side
  output logic                    ext_irq_input_o,
  output logic [7:0]              key_return_inputs_o,
  output logic                    irq_o
);

  localparam int N = `PPM_NPINS;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [N-1:0]        out_q;
  logic [N-1:0]        dir_q;
  logic [N-1:0]        pullup_option_reg_q;
  logic [1:0]          output_drive_mode_reg_a_q;
  logic [6:0]          output_drive_mode_reg_b_q;
  logic [5:0]          func_q;
  logic [1:0]          istat_q;
  logic [1:0]          istat_d;
  logic [1:0]          ien_q;
  ppm_pkg::ppm_bus_st_t bus_q;
  ppm_pkg::ppm_edge_t  edge_sel;

  logic [N-1:0]        pins_in;
  logic [N-1:0]        alt_en;
  logic [N-1:0]        alt_val;
  logic [N-1:0]        oe_gate;
  logic [N-1:0]        od_sel;
  logic [N-1:0]        pin_o_d;
  logic [N-1:0]        pin_oe_d;
  logic [N-1:0]        pu_d;
  logic [N-1:0]        pin_o_q;
  logic [N-1:0]        pin_oe_q;
  logic [N-1:0]        pu_q;

  logic                req;
  logic                wr;
  logic [31:0]         wmask;
  logic [31:0]         rdata;
  logic                ext_evt;
  logic [7:0]          kr_evt;
  logic [1:0]          irq_clr;

  assign pins_in = {port4_pins_i, port2_pins_i, port1_pins_i, port0_pins_i};
  assign edge_sel = ppm_pkg::ppm_edge_t'(func_q[`PPM_FN_EDGE_LSB +: 2]);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign req = wb_req_i.cyc & wb_req_i.stb & (bus_q == ppm_pkg::PPM_BUS_IDLE);
  assign wr  = req & wb_req_i.we;

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[8*b +: 8] = {8{wb_req_i.sel[b]}};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_q <= ppm_pkg::PPM_BUS_IDLE;
    else
    begin
      case (bus_q)
        ppm_pkg::PPM_BUS_IDLE:
          if (req)
            bus_q <= ppm_pkg::PPM_BUS_ACK;
        ppm_pkg::PPM_BUS_ACK:
          bus_q <= ppm_pkg::PPM_BUS_IDLE;
        default:
          bus_q <= ppm_pkg::PPM_BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = bus_q[1];

  // --------------------------------------------------------------------------
  // Output latches
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_q <= '0;
    else if (wr)
    begin
      case (wb_req_i.adr)
        `PPM_OUT0_OFS: out_q[`PPM_P0_LSB +: 8] <=
          (out_q[`PPM_P0_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]);
        `PPM_OUT1_OFS: out_q[`PPM_P1_LSB +: 8] <=
          (out_q[`PPM_P1_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]);
        `PPM_OUT2_OFS: out_q[`PPM_P2_LSB +: 7] <=
          (out_q[`PPM_P2_LSB +: 7] & ~wmask[6:0]) | (wb_req_i.dat[6:0] & wmask[6:0]); // RL2
        `PPM_OUT4_OFS: out_q[`PPM_P4_LSB +: 8] <=
          (out_q[`PPM_P4_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]);
        default: out_q <= out_q;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Direction registers, one bit per pin, set means input
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dir_q <= {`PPM_DIR_RST, 7'h7F, `PPM_DIR_RST, `PPM_DIR_RST}; // RL6
    else if (wr)
    begin
      case (wb_req_i.adr)
        `PPM_DIR0_OFS: dir_q[`PPM_P0_LSB +: 8] <=
          (dir_q[`PPM_P0_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]); // RL11
        `PPM_DIR1_OFS: dir_q[`PPM_P1_LSB +: 8] <=
          (dir_q[`PPM_P1_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]); // RL1
        `PPM_DIR2_OFS: dir_q[`PPM_P2_LSB +: 7] <=
          (dir_q[`PPM_P2_LSB +: 7] & ~wmask[6:0]) | (wb_req_i.dat[6:0] & wmask[6:0]); // RL2
        `PPM_DIR4_OFS: dir_q[`PPM_P4_LSB +: 8] <=
          (dir_q[`PPM_P4_LSB +: 8] & ~wmask[7:0]) | (wb_req_i.dat[7:0] & wmask[7:0]); // RL1
        default: dir_q <= dir_q;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pull-up option, drive mode and function registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pullup_option_reg_q <= '0;
    else if (wr && wb_req_i.adr == `PPM_PULLUP_OFS)
      pullup_option_reg_q <= (pullup_option_reg_q & ~wmask[N-1:0]) |
                             (wb_req_i.dat[N-1:0] & wmask[N-1:0]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      output_drive_mode_reg_a_q <= '0;
    else if (wr && wb_req_i.adr == `PPM_DRVA_OFS && wb_req_i.sel[0])
      output_drive_mode_reg_a_q <= wb_req_i.dat[1:0]; // RL4
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      output_drive_mode_reg_b_q <= '0;
    else if (wr && wb_req_i.adr == `PPM_DRVB_OFS && wb_req_i.sel[0])
    begin
      output_drive_mode_reg_b_q[`PPM_DRVB_P25] <= wb_req_i.dat[`PPM_DRVB_P25]; // RL5
      output_drive_mode_reg_b_q[`PPM_DRVB_P26] <= wb_req_i.dat[`PPM_DRVB_P26]; // RL5
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      func_q <= '0;
    else if (wr && wb_req_i.adr == `PPM_FUNC_OFS && wb_req_i.sel[0])
      func_q <= wb_req_i.dat[5:0];
  end

  // --------------------------------------------------------------------------
  // Interrupt status, clear and enable
  // --------------------------------------------------------------------------
  assign irq_clr = (wr && wb_req_i.adr == `PPM_ICLR_OFS && wb_req_i.sel[0]) ?
                   wb_req_i.dat[1:0] : 2'h0;

  // A new event in the clearing cycle keeps its bit set.
  always_comb
  begin
    istat_d = istat_q & ~irq_clr;
    istat_d[`PPM_IRQ_EXT_BIT] = istat_d[`PPM_IRQ_EXT_BIT] | ext_evt;
    istat_d[`PPM_IRQ_KR_BIT]  = istat_d[`PPM_IRQ_KR_BIT] | (|kr_evt);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      istat_q <= '0;
    else
      istat_q <= istat_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ien_q <= '0;
    else if (wr && wb_req_i.adr == `PPM_IEN_OFS && wb_req_i.sel[0])
      ien_q <= wb_req_i.dat[1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(istat_q & ien_q);
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb
  begin
    rdata = `PPM_ZERO_RST;
    case (wb_req_i.adr)
      `PPM_OUT0_OFS:   rdata[7:0]   = out_q[`PPM_P0_LSB +: 8];
      `PPM_OUT1_OFS:   rdata[7:0]   = out_q[`PPM_P1_LSB +: 8];
      `PPM_OUT2_OFS:   rdata[6:0]   = out_q[`PPM_P2_LSB +: 7];
      `PPM_OUT4_OFS:   rdata[7:0]   = out_q[`PPM_P4_LSB +: 8];
      `PPM_DIR0_OFS:   rdata[7:0]   = dir_q[`PPM_P0_LSB +: 8];
      `PPM_DIR1_OFS:   rdata[7:0]   = dir_q[`PPM_P1_LSB +: 8];
      `PPM_DIR2_OFS:   rdata[6:0]   = dir_q[`PPM_P2_LSB +: 7];
      `PPM_DIR4_OFS:   rdata[7:0]   = dir_q[`PPM_P4_LSB +: 8];
      `PPM_PULLUP_OFS: rdata[N-1:0] = pullup_option_reg_q;
      `PPM_DRVA_OFS:   rdata[1:0]   = output_drive_mode_reg_a_q;
      `PPM_DRVB_OFS:   rdata[6:0]   = output_drive_mode_reg_b_q;
      `PPM_FUNC_OFS:   rdata[5:0]   = func_q;
      `PPM_PINS_OFS:   rdata[N-1:0] = pins_in;
      `PPM_ISTAT_OFS:  rdata[1:0]   = istat_q;
      `PPM_IEN_OFS:    rdata[1:0]   = ien_q;
      default:         rdata        = `PPM_ZERO_RST;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= `PPM_ZERO_RST;
    else if (req)
      wb_dat_o <= wb_req_i.we ? `PPM_ZERO_RST : rdata;
  end

  // --------------------------------------------------------------------------
  // Alternate function selection
  // --------------------------------------------------------------------------
  always_comb
  begin
    alt_en  = '0;
    alt_val = '0;
    oe_gate = '1;
    if (func_q[`PPM_FN_SER_BIT])
    begin
      alt_en[`PPM_SCK_BIT]  = 1'b1; // RL7
      alt_val[`PPM_SCK_BIT] = serial_clock_drv_i; // RL7
      oe_gate[`PPM_SCK_BIT] = serial_clock_oe_i; // RL7
      alt_en[`PPM_SO_BIT]   = 1'b1; // RL7
      alt_val[`PPM_SO_BIT]  = serial_out_drv_i; // RL7
    end
    if (func_q[`PPM_FN_TO_BIT])
    begin
      alt_en[`PPM_P26_BIT]  = 1'b1; // RL8
      alt_val[`PPM_P26_BIT] = timer_output_pin_i; // RL8
    end
  end

  always_comb
  begin
    od_sel = '0;
    od_sel[`PPM_P0_LSB +: 8] = {8{output_drive_mode_reg_a_q[`PPM_DRVA_P0_BIT]}}; // RL4
    od_sel[`PPM_P1_LSB +: 8] = {8{output_drive_mode_reg_a_q[`PPM_DRVA_P1_BIT]}}; // RL4
    od_sel[`PPM_P25_BIT] = output_drive_mode_reg_b_q[`PPM_DRVB_P25]; // RL5
    od_sel[`PPM_P26_BIT] = output_drive_mode_reg_b_q[`PPM_DRVB_P26]; // RL5
  end

  // --------------------------------------------------------------------------
  // Per-pin drive; open drain only ever drives low
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < N; i++)
  begin : g_pin
    logic val;
    assign val         = alt_en[i] ? alt_val[i] : out_q[i];
    assign pin_o_d[i]  = val & ~od_sel[i]; // RL4
    assign pin_oe_d[i] = ~dir_q[i] & oe_gate[i] & (~od_sel[i] | ~val); // RL6
    assign pu_d[i]     = dir_q[i] & pullup_option_reg_q[i]; // RL3 RL13
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o_q  <= '0;
      pin_oe_q <= '0;
      pu_q     <= '0;
    end
    else
    begin
      pin_o_q  <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      pu_q     <= pu_d;
    end
  end

  assign port0_pins_o    = pin_o_q[`PPM_P0_LSB +: 8];
  assign port1_pins_o    = pin_o_q[`PPM_P1_LSB +: 8];
  assign port2_pins_o    = pin_o_q[`PPM_P2_LSB +: 7];
  assign port4_pins_o    = pin_o_q[`PPM_P4_LSB +: 8];
  assign port0_pins_oe_o = pin_oe_q[`PPM_P0_LSB +: 8];
  assign port1_pins_oe_o = pin_oe_q[`PPM_P1_LSB +: 8];
  assign port2_pins_oe_o = pin_oe_q[`PPM_P2_LSB +: 7];
  assign port4_pins_oe_o = pin_oe_q[`PPM_P4_LSB +: 8];
  assign port0_pullup_o  = pu_q[`PPM_P0_LSB +: 8];
  assign port1_pullup_o  = pu_q[`PPM_P1_LSB +: 8];
  assign port2_pullup_o  = pu_q[`PPM_P2_LSB +: 7];
  assign port4_pullup_o  = pu_q[`PPM_P4_LSB +: 8];

  // --------------------------------------------------------------------------
  // Inputs routed to peripherals
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_clock_pin_o     <= 1'b0;
      serial_in_pin_o        <= 1'b0;
      timer_count_clock_in_o <= 1'b0;
    end
    else
    begin
      serial_clock_pin_o     <= func_q[`PPM_FN_SER_BIT] & pins_in[`PPM_SCK_BIT]; // RL7
      serial_in_pin_o        <= func_q[`PPM_FN_SER_BIT] & pins_in[`PPM_SI_BIT]; // RL7
      timer_count_clock_in_o <= func_q[`PPM_FN_TI_BIT] & pins_in[`PPM_P26_BIT]; // RL8
    end
  end

  // --------------------------------------------------------------------------
  // External interrupt and key-return edge detection
  // --------------------------------------------------------------------------
  ppm_edge_det #(
    .W (1)
  ) u_ext_edge (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (dir_q[`PPM_P26_BIT]), // RL8
    .rise_en_i (edge_sel[0]), // RL9
    .fall_en_i (edge_sel[1]), // RL9
    .lvl_i     (pins_in[`PPM_P26_BIT]),
    .evt_o     (ext_evt)
  );

  // Key-return lines are active low, so the falling edge is the event.
  ppm_edge_det #(
    .W (8)
  ) u_kr_edge (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .en_i      (func_q[`PPM_FN_KR_BIT]), // RL10
    .rise_en_i (1'b0),
    .fall_en_i (1'b1),
    .lvl_i     (pins_in[`PPM_P4_LSB +: 8] | ~dir_q[`PPM_P4_LSB +: 8]), // RL10
    .evt_o     (kr_evt)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_irq_input_o     <= 1'b0;
      key_return_inputs_o <= 8'h00;
    end
    else
    begin
      ext_irq_input_o     <= ext_evt; // RL9
      key_return_inputs_o <= kr_evt; // RL10
    end
  end

endmodule // ppm_top

// file: sim/ppm_board.sv
// Board circuitry model that resolves the levels on the 31 port pins.
`timescale 1ns/10ps
module ppm_board (
  // Clock
  input  wire logic        clk_i,
  // Device side
  input  wire logic [30:0] oe_i,
  input  wire logic [30:0] dout_i,
  input  wire logic [30:0] pullup_i,
  // Bench side
  input  wire logic [30:0] ext_en_i,
  input  wire logic [30:0] ext_val_i,
  // Pin levels
  output logic      [30:0] pin_o
);
  logic [30:0] last_q = 31'h0;
  always @(posedge clk_i) last_q <= pin_o;
  // A floating pin shows the inverse of its last level.
  always_comb
    for (int i = 0; i < 31; i++)
      pin_o[i] = oe_i[i] ? dout_i[i] : ext_en_i[i] ? ext_val_i[i] :
                 pullup_i[i] ? 1'b1 : ~last_q[i];
endmodule // ppm_board

// file: sim/ppm_checker_assertions.sv
// Checker of bus timing, pin drive and event outputs of the port block.
`timescale 1ns/10ps
module ppm_checker (
  // Clock, reset and bus
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire ppm_pkg::ppm_wb_req_t wb_req_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  // Pin drive
  input wire logic [7:0]           port0_pins_oe_o,
  input wire logic [7:0]           port1_pins_oe_o,
  input wire logic [6:0]           port2_pins_oe_o,
  input wire logic [7:0]           port4_pins_oe_o,
  input wire logic [7:0]           port0_pullup_o,
  input wire logic [7:0]           port1_pullup_o,
  input wire logic [6:0]           port2_pullup_o,
  input wire logic [7:0]           port4_pullup_o,
  // Events
  input wire logic                 ext_irq_input_o,
  input wire logic [7:0]           key_return_inputs_o,
  input wire logic                 irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        req;
  logic [30:0] oe;
  logic [30:0] pu;
  assign req = wb_req_i.cyc & wb_req_i.stb;
  assign oe = {port4_pins_oe_o, port2_pins_oe_o, port1_pins_oe_o,
               port0_pins_oe_o};
  assign pu = {port4_pullup_o, port2_pullup_o, port1_pullup_o,
               port0_pullup_o};
  ack_delay_a:
    assert property (req && !wb_ack_o |=> wb_ack_o) else $error("late ack");
  ack_single_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  ack_cause_a:
    assert property (!req |=> !wb_ack_o) else $error("stray ack");
  write_data_a:
    assert property (wb_ack_o && wb_req_i.we |-> wb_dat_o == 32'h0)
      else $error("write data not zero");
  pullup_out_a:
    assert property ((oe & pu) == 31'h0) else $error("pull-up on output");
  reset_input_a:
    assert property ($fell(rst_i) |-> oe == 31'h0 && pu == 31'h0)
      else $error("pin not input after reset");
  oe_cause_a:
    assert property ($changed(oe & 31'h7FFE_FFFF) |-> $past(wb_ack_o))
      else $error("drive changed without write");
  pullup_cause_a:
    assert property ($changed(pu) |-> $past(wb_ack_o))
      else $error("pull-up changed without write");
  irq_cause_a:
    assert property ($rose(irq_o) |-> wb_ack_o || $past(wb_ack_o) ||
      $past(ext_irq_input_o || (|key_return_inputs_o)))
      else $error("interrupt without cause");
  ext_pulse_a:
    assert property (ext_irq_input_o |=> !ext_irq_input_o)
      else $error("long edge pulse");
endmodule // ppm_checker

bind ppm_top ppm_checker u_ppm_checker (.*);

// file: sim/tb_top.sv
// Self-checking bench for the port pin and alternate function block.
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
bad_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  ppm_pkg::ppm_wb_req_t wb_req_i = '0;
  logic [31:0]          wb_dat_o, rd_q;
  logic                 wb_ack_o, irq_o, sck_in, ser_in, tmr_in, ext_irq;
  logic                 sck_drv = 0, sck_oe = 0, so_drv = 0, to_drv = 0;
  logic [7:0]           key;
  logic [30:0]          pins;
  wire  [30:0]          pout, poe, ppu;
  logic [30:0]          ext_en = '0, ext_val = '0;
  int                   bad_count, samples_checked, n_ext, n_key, c;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) n_ext += ext_irq;
  always @(posedge clk_i) n_key += $countones(key);
  ppm_top u_ppm_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .port0_pins_i(pins[7:0]), .port0_pins_o(pout[7:0]),
    .port0_pins_oe_o(poe[7:0]), .port0_pullup_o(ppu[7:0]),
    .port1_pins_i(pins[15:8]), .port1_pins_o(pout[15:8]),
    .port1_pins_oe_o(poe[15:8]), .port1_pullup_o(ppu[15:8]),
    .port2_pins_i(pins[22:16]), .port2_pins_o(pout[22:16]),
    .port2_pins_oe_o(poe[22:16]), .port2_pullup_o(ppu[22:16]),
    .port4_pins_i(pins[30:23]), .port4_pins_o(pout[30:23]),
    .port4_pins_oe_o(poe[30:23]), .port4_pullup_o(ppu[30:23]),
    .serial_clock_drv_i(sck_drv), .serial_clock_oe_i(sck_oe),
    .serial_out_drv_i(so_drv), .serial_clock_pin_o(sck_in),
    .serial_in_pin_o(ser_in), .timer_output_pin_i(to_drv),
    .timer_count_clock_in_o(tmr_in), .ext_irq_input_o(ext_irq),
    .key_return_inputs_o(key), .irq_o(irq_o));
  ppm_board u_ppm_board (.clk_i(clk_i), .oe_i(poe), .dout_i(pout),
    .pullup_i(ppu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pins));
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_req_i <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_req_i <= '0;
    `CHK("ack", 1'b1, wb_ack_o)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    `CHK($sformatf("reg %h", a), e, rd_q)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    `CHK("oe", 31'h0, poe)
    rd(8'h10, 32'hFF);
    rd(8'h18, 32'h7F);
    rd(8'h40, 32'h0);
    wb(8'h20, 1, 32'h7FFF_FFFF);
    settle(2);
    `CHK("pullup", 31'h7FFF_FFFF, ppu)
    rd(8'h30, 32'h7FFF_FFFF);
    for (int p = 0; p < 4; p++)
    begin
      wb(8'(p * 4), 1, 32'hA5);
      wb(8'(16 + p * 4), 1, 32'h0);
    end
    settle(2);
    `CHK("pullup", 31'h0, ppu)
    `CHK("oe", 31'h7FFF_FFFF, poe)
    rd(8'h30, {1'b0, 8'hA5, 7'h25, 16'hA5A5});
    $display("test direction finished");
    wb(8'h24, 1, 32'h1);
    settle(2);
    `CHK("oe", {8'hFF, 7'h7F, 16'hFF5A}, poe)
    `CHK("out", {8'hA5, 7'h25, 16'hA500}, pout)
    wb(8'h24, 1, 32'h2);
    wb(8'h08, 1, 32'h7F);
    settle(2);
    `CHK("oe", {8'hFF, 7'h7F, 16'h5AFF}, poe)
    for (int b = 5; b < 7; b++)
    begin
      wb(8'h28, 1, 32'(1 << b));
      settle(2);
      `CHK("p2 oe", 7'h7F & ~7'(1 << b), poe[22:16])
    end
    $display("test drive mode finished");
    wb(8'h28, 1, 32'h0);
    wb(8'h2C, 1, 32'h3);
    wb(8'h18, 1, 32'h3C);
    ext_en[18] <= 1'b1;
    sck_oe <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk_i);
      {sck_drv, ext_val[18], to_drv, so_drv} <= {{3{v[0]}}, ~v[0]};
      settle(3);
      `CHK("sck", v[0], pout[16])
      `CHK("so", ~v[0], pout[17])
      `CHK("si", v[0], ser_in)
      `CHK("sck in", v[0], sck_in)
      `CHK("tmr out", v[0], pout[22])
    end
    @(posedge clk_i);
    sck_oe <= 1'b0;
    settle(2);
    `CHK("sck oe", 1'b0, poe[16])
    $display("test serial and timer finished");
    wb(8'h18, 1, 32'h7F);
    to_drv <= 1'b0;
    ext_en[22] <= 1'b1;
    wb(8'h3C, 1, 32'h1);
    for (int e = 0; e < 4; e++)
    begin
      wb(8'h2C, 1, 32'h4 | 32'(e << 4));
      wb(8'h38, 1, 32'h1);
      c = n_ext;
      ext_val[22] <= 1'b1;
      settle(6);
      `CHK("tmr clk", 1'b1, tmr_in)
      @(posedge clk_i);
      ext_val[22] <= 1'b0;
      settle(6);
      `CHK("edges", (e == 3) ? 2 : (e != 0), n_ext - c)
      `CHK("irq", e != 0, irq_o)
      rd(8'h34, 32'(e != 0));
    end
    $display("test edge select finished");
    ext_val[30:23] <= 8'hFF;
    ext_en[30:23] <= 8'hFF;
    wb(8'h1C, 1, 32'hFF);
    wb(8'h3C, 1, 32'h0);
    wb(8'h2C, 1, 32'h8);
    wb(8'h38, 1, 32'h3);
    c = n_key;
    ext_val[30:23] <= 8'h00;
    settle(6);
    `CHK("keys", 8, n_key - c)
    rd(8'h34, 32'h2);
    `CHK("irq", 1'b0, irq_o)
    wb(8'h3C, 1, 32'h2);
    settle(2);
    `CHK("irq", 1'b1, irq_o)
    wb(8'h38, 1, 32'h2);
    settle(2);
    `CHK("irq", 1'b0, irq_o)
    $display("test key return finished");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(1);
    `CHK("oe", 31'h0, poe)
    rd(8'h1C, 32'hFF);
    test_done();
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    test_done();
  end
endmodule // tb_top
